// [inc/pnsr_map.svh]
`ifndef PNSR_MAP_SVH
`define PNSR_MAP_SVH
// I/O addresses of the ports.
`define PNSR_ADDR_SPKR 10'h061
`define PNSR_ADDR_NMIMASK 10'h070
`define PNSR_ADDR_SYSCTL 10'h092
`define PNSR_ADDR_SHADOW 10'h09F
// System control port fields.
`define PNSR_SYS_RST_BIT 0
`define PNSR_SYS_A20_BIT 1
// Speaker and NMI port fields.
`define PNSR_SPK_GATE_BIT 0
`define PNSR_SPK_DATA_BIT 1
`define PNSR_SPK_PAR_EN_BIT 2
`define PNSR_SPK_CHK_EN_BIT 3
`define PNSR_SPK_REF_BIT 4
`define PNSR_SPK_PAR_ST_BIT 7
`define PNSR_SPK_CHK_ST_BIT 6
`define PNSR_NMI_MASK_BIT 7
// Shadow unlock counts and reset values.
`define PNSR_UNLOCK_RER 4'h8
`define PNSR_UNLOCK_WPR 4'h9
`define PNSR_SHD_RST 6'h00
`define PNSR_SHD_PAD 2'b11
// Shadowable blocks start at 64K block 0A; ROM blocks are 0E and 0F, duplicated at FE and FF.
`define PNSR_SHD_BASE 8'h0A
`define PNSR_ROM_BLK_LO 8'h0E
`define PNSR_ROM_DUP_LO 8'hFE
`define PNSR_TEST_CFG_A 3'b000
`define PNSR_TEST_CFG_B 3'b100
`endif

// [inc/pnsr_pkg.sv]
package pnsr_pkg;
	// One bus cycle strobe event seen by the ports.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [9:0] addr;
		logic [7:0] data;
	} pnsr_io_s;
	// Memory decode outputs of the shadow logic.
	typedef struct packed {
		logic fast;
		logic row;
		logic col;
		logic rom;
		logic lmeg;
	} pnsr_mem_s;
endpackage

// [hdl/pnsr_ctrl.sv]
`timescale 1ns/100ps
`include "pnsr_map.svh"
// What this block does
// R1: Gated address 20 follows CPU bit 20 when gate input or control bit 1 high.
// R2: Address bit 0 flows slot to peripheral when DMA enable high, else reverse.
// R3: Control port at 92h; bit 0 drives soft reset, bit 1 alternate gate.
// R4: Control bits clear on reset; reads return zero in bits 2 to 7.
// R5: Speaker and NMI port at 61h is read/write, controls speaker and NMI masks.
// R6: Reading 61h returns refresh status, speaker data and NMI source status.
// R7: NMI from parity error or channel check low, each gated by its enable.
// R8: NMI masked after reset; write 70h bit 7 low unmasks, high masks.
// R9: Two 6-bit shadow registers work only while shadow map select is high.
// R10: Space 0A0000h to 0FFFFFh is six 64K blocks, one bit each.
// R11: Eight writes to 9Fh unlock; ninth loads read-enable, tenth write-protect.
// R12: Unlock counter clears on other writes, any read, reset, tenth write.
// R13: Reads of 9Fh alternate read-enable then write-protect; writes clear pointer.
// R14: Shadow registers clear on reset; bits 6 and 7 read as one.
// R15: Config select 000 or 100 puts every output in high impedance test mode.
// R16: Shadow map select low means normal decode, no shadow-caused strobes.
// R17: Read-enabled block goes to shadow RAM with fast and column strobes.
// R18: Shadow read with read-enable asserts fast, row, column and lmeg, ROM select only in ROM blocks; clear means normal read.
// R19: Write with read-enable clear is slow outside ROM blocks 0E-0F and FE-FF; column only if not protected.
// R20: Write with read-enable set is fast; column withheld when protected.
// R21: Fast cycle always for blocks 0E-0F and FE-FF, the only ROM select regions.
// R22: All state updates on the clock, strobes detected once per bus cycle.
module pnsr_ctrl
	import pnsr_pkg::*;
#(
	parameter int SHD_BLOCKS = 6
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cpu_addr_bit20_in,
	input wire logic addr20_gate_in,
	input wire logic dma_addr_enable_n,
	input wire logic slot_addr_bit0_in,
	input wire logic peripheral_addr_bit0_in,
	input wire logic io_write_strobe_n,
	input wire logic io_read_strobe_n,
	input wire logic [9:0] io_addr,
	input wire logic [7:0] io_data_in,
	input wire logic channel_check_n,
	input wire logic parity_error_n,
	input wire logic refresh_n,
	input wire logic shadow_map_select,
	input wire logic [2:0] ram_config_select,
	input wire logic early_ram_write_n,
	input wire logic [7:0] mem_block,
	output logic gated_addr_bit20,
	output logic gated_addr_bit20_oe,
	output logic soft_reset_out,
	output logic soft_reset_oe,
	output logic slot_addr_bit0_out,
	output logic slot_addr_bit0_oe,
	output logic peripheral_addr_bit0_out,
	output logic peripheral_addr_bit0_oe,
	output logic [7:0] io_data_out,
	output logic io_data_oe,
	output logic nmi_out,
	output logic nmi_oe,
	output logic speaker_out,
	output logic speaker_oe,
	output pnsr_mem_s mem_out,
	output logic mem_oe
);
	// ==================================================================
	// Input synchronisers.
	// ==================================================================
	logic [15:0] s1_q, s2_q;
	logic [9:0] a1_q, a2_q;
	logic [7:0] d1_q, d2_q;
	logic [15:0] s_in;
	logic iow, ior, chk, par, refr, test_mode;
	logic iow_prev_q, ior_prev_q;
	pnsr_io_s io;

	// The raw pin group feeding the two-stage synchroniser.
	always_comb begin
		s_in = {io_write_strobe_n, io_read_strobe_n, channel_check_n, parity_error_n,
			refresh_n, shadow_map_select, ram_config_select, early_ram_write_n, 6'h00};
	end

	// Two flip-flops on the strobe, status, select and I/O address and data pins before use; only the second is read.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 16'hFFFF;
			s2_q <= 16'hFFFF;
			a1_q <= 10'h000;
			a2_q <= 10'h000;
			d1_q <= 8'h00;
			d2_q <= 8'h00;
			iow_prev_q <= 1'b0;
			ior_prev_q <= 1'b0;
		end else begin
			s1_q <= s_in;
			s2_q <= s1_q;
			a1_q <= io_addr;
			a2_q <= a1_q;
			d1_q <= io_data_in;
			d2_q <= d1_q;
			iow_prev_q <= iow;
			ior_prev_q <= ior;
		end
	end

	// Strobe levels and single-cycle events per bus cycle.
	always_comb begin
		iow = ~s2_q[15];
		ior = ~s2_q[14];
		chk = ~s2_q[13];
		par = ~s2_q[12];
		refr = ~s2_q[11];
		test_mode = (s2_q[9:7] == `PNSR_TEST_CFG_A) || (s2_q[9:7] == `PNSR_TEST_CFG_B); // R15
		io.wr = iow & ~iow_prev_q; // R22
		io.rd = ior & ~ior_prev_q; // R22
		io.addr = a2_q;
		io.data = d2_q;
	end

	// ==================================================================
	// Port registers, NMI mask and shadow registers.
	// ==================================================================
	logic [1:0] sys_q, sys_d;
	logic [3:0] spk_q, spk_d;
	logic nmi_mask_q, nmi_mask_d;
	logic [SHD_BLOCKS-1:0] rer_q, rer_d, wpr_q, wpr_d;
	logic [3:0] unlock_q, unlock_d;
	logic rptr_q, rptr_d;
	logic [7:0] rdat_q, rdat_d;
	logic rdv_q, rdv_d;
	logic wr_shd;

	// Next-state logic for every register of the port group.
	always_comb begin
		sys_d = sys_q;
		spk_d = spk_q;
		nmi_mask_d = nmi_mask_q;
		rer_d = rer_q;
		wpr_d = wpr_q;
		unlock_d = unlock_q;
		rptr_d = rptr_q;
		rdat_d = rdat_q;
		rdv_d = ior & rdv_q;
		wr_shd = io.wr && (io.addr == `PNSR_ADDR_SHADOW);
		if (io.wr) begin
			rptr_d = 1'b0; // R13
			if (io.addr == `PNSR_ADDR_SYSCTL) begin
				sys_d = io.data[1:0]; // R3
			end
			if (io.addr == `PNSR_ADDR_SPKR) begin
				spk_d = io.data[3:0]; // R5
			end
			if (io.addr == `PNSR_ADDR_NMIMASK) begin
				nmi_mask_d = io.data[`PNSR_NMI_MASK_BIT]; // R8
			end
			if (!wr_shd || unlock_q == `PNSR_UNLOCK_WPR) begin
				unlock_d = 4'h0; // R12
			end else begin
				unlock_d = unlock_q + 4'h1; // R11
			end
			if (wr_shd && unlock_q == `PNSR_UNLOCK_RER) begin
				rer_d = io.data[SHD_BLOCKS-1:0]; // R11
			end
			if (wr_shd && unlock_q == `PNSR_UNLOCK_WPR) begin
				wpr_d = io.data[SHD_BLOCKS-1:0]; // R11
			end
		end
		if (io.rd) begin
			unlock_d = 4'h0; // R12
			rdv_d = 1'b1;
			rdat_d = 8'h00;
			case (io.addr)
				`PNSR_ADDR_SYSCTL: begin
					rdat_d = {6'h00, sys_q}; // R4
				end
				`PNSR_ADDR_SPKR: begin
					rdat_d = {par & spk_q[2], chk & spk_q[3], 1'b0, refr, spk_q}; // R6
				end
				`PNSR_ADDR_SHADOW: begin
					rdat_d = {`PNSR_SHD_PAD, rptr_q ? wpr_q : rer_q}; // R14
					rptr_d = ~rptr_q; // R13
				end
				default: begin
					rdv_d = 1'b0;
				end
			endcase
		end
	end

	// Register the port group; all clear on reset except the NMI mask, which sets.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_q <= 2'b00; // R4
			spk_q <= 4'h0;
			nmi_mask_q <= 1'b1; // R8
			rer_q <= `PNSR_SHD_RST; // R14
			wpr_q <= `PNSR_SHD_RST; // R14
			unlock_q <= 4'h0;
			rptr_q <= 1'b0;
			rdat_q <= 8'h00;
			rdv_q <= 1'b0;
		end else begin
			sys_q <= sys_d;
			spk_q <= spk_d;
			nmi_mask_q <= nmi_mask_d;
			rer_q <= rer_d;
			wpr_q <= wpr_d;
			unlock_q <= unlock_d;
			rptr_q <= rptr_d;
			rdat_q <= rdat_d;
			rdv_q <= rdv_d;
		end
	end

	// ==================================================================
	// Pin outputs and shadow decode.
	// ==================================================================
	logic [7:0] blk_idx;
	logic in_shd, is_rom, re_bit, wp_bit, rd_cyc;
	pnsr_mem_s dec;

	// Shadow decode of the current memory block.
	always_comb begin
		blk_idx = mem_block - `PNSR_SHD_BASE;
		in_shd = (mem_block >= `PNSR_SHD_BASE) && (blk_idx < 8'(SHD_BLOCKS)); // R10
		is_rom = (mem_block[7:1] == 7'(`PNSR_ROM_BLK_LO >> 1))
			|| (mem_block[7:1] == 7'(`PNSR_ROM_DUP_LO >> 1));
		re_bit = in_shd ? rer_q[blk_idx[2:0]] : is_rom & rer_q[SHD_BLOCKS-1];
		wp_bit = in_shd ? wpr_q[blk_idx[2:0]] : is_rom & wpr_q[SHD_BLOCKS-1];
		rd_cyc = s2_q[6];
		dec = '0;
		if (s2_q[10] && (in_shd || is_rom)) begin // R9 R16
			dec.row = 1'b1;
			if (re_bit) begin
				dec.fast = 1'b1; // R17 R18 R20
				dec.rom = is_rom; // R17 R21
				dec.lmeg = 1'b1;
				dec.col = rd_cyc | ~wp_bit; // R18 R20
			end else if (!rd_cyc) begin
				dec.rom = is_rom; // R19 R21
				dec.col = ~wp_bit; // R19
			end
		end
		if (is_rom) begin
			dec.fast = 1'b1; // R21
		end
	end

	// Combinational pin drive; test mode disables every enable.
	always_comb begin
		gated_addr_bit20 = cpu_addr_bit20_in & (addr20_gate_in | sys_q[`PNSR_SYS_A20_BIT]); // R1
		soft_reset_out = sys_q[`PNSR_SYS_RST_BIT]; // R3
		slot_addr_bit0_out = peripheral_addr_bit0_in;
		peripheral_addr_bit0_out = slot_addr_bit0_in;
		peripheral_addr_bit0_oe = dma_addr_enable_n & ~test_mode; // R2
		slot_addr_bit0_oe = ~dma_addr_enable_n & ~test_mode; // R2
		nmi_out = ~nmi_mask_q & ((par & spk_q[`PNSR_SPK_PAR_EN_BIT])
			| (chk & spk_q[`PNSR_SPK_CHK_EN_BIT])); // R7
		speaker_out = spk_q[`PNSR_SPK_GATE_BIT] & spk_q[`PNSR_SPK_DATA_BIT];
		io_data_out = rdat_q;
		io_data_oe = rdv_q & ~test_mode;
		mem_out = dec;
		gated_addr_bit20_oe = ~test_mode; // R15
		soft_reset_oe = ~test_mode;
		nmi_oe = ~test_mode;
		speaker_oe = ~test_mode;
		mem_oe = ~test_mode;
	end

	// ==================================================================
	// Assertions.
	// ==================================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a20_gate_a: assert property (!addr20_gate_in && !sys_q[`PNSR_SYS_A20_BIT] |-> !gated_addr_bit20) // R1
		else $error("gated address 20 not forced low");
	dir_a: assert property (dma_addr_enable_n |-> !slot_addr_bit0_oe) // R2
		else $error("address bit 0 driven both ways");
	sysrd_a: assert property (io.rd && io.addr == `PNSR_ADDR_SYSCTL
		|=> rdat_q[7:2] == 6'h00 && rdat_q[1:0] == $past(sys_q)) // R4
		else $error("control port read wrong");
	sysw_a: assert property (io.wr && io.addr == `PNSR_ADDR_SYSCTL
		|=> soft_reset_out == $past(io.data[`PNSR_SYS_RST_BIT])) // R3
		else $error("soft reset not from bit 0");
	nmi_mask_a: assert property (nmi_mask_q |-> !nmi_out) // R8
		else $error("NMI while masked");
	unlock_clr_a: assert property (io.rd |=> unlock_q == 4'h0) // R12
		else $error("unlock count kept over read");
	rer_hold_a: assert property (io.wr && unlock_q != `PNSR_UNLOCK_RER |=> rer_q == $past(rer_q)) // R11
		else $error("read-enable written while locked");
	ptr_alt_a: assert property (io.rd && io.addr == `PNSR_ADDR_SHADOW && !io.wr
		|=> rptr_q != $past(rptr_q)) // R13
		else $error("read pointer did not toggle");
	shd_pad_a: assert property (io.rd && io.addr == `PNSR_ADDR_SHADOW |=> rdat_q[7:6] == 2'b11) // R14
		else $error("shadow pad bits not one");
	test_a: assert property (test_mode |-> !mem_oe && !io_data_oe && !nmi_oe) // R15
		else $error("output driven in test mode");
	noshd_a: assert property (!s2_q[10] && !is_rom |-> mem_out == '0) // R16
		else $error("shadow strobes with map off");
	wp_a: assert property (s2_q[10] && in_shd && !rd_cyc && wp_bit |-> !mem_out.col) // R19
		else $error("column on protected write");
	rom_only_a: assert property (mem_out.rom |-> is_rom) // R21
		else $error("ROM select outside ROM blocks");

	unlock_c: cover property (io.wr && unlock_q == `PNSR_UNLOCK_WPR);
	nmi_c: cover property (nmi_out);
	fast_rd_c: cover property (s2_q[10] && in_shd && rd_cyc && re_bit);
endmodule

// [testbench/pnsr_host_model.sv]
`timescale 1ns/100ps
// ====================
// Host I/O bus cycles.
module pnsr_host_model (
	input wire logic clk,
	input wire logic data_oe,
	input wire logic [7:0] data_out,
	output logic wr_n,
	output logic rd_n,
	output logic [9:0] addr,
	output logic [7:0] data
);
	// Strobes idle high so no cycle is seen before the first request.
	initial begin
		wr_n = 1'b1;
		rd_n = 1'b1;
		addr = 10'h000;
		data = 8'h00;
	end
	// Write cycle; the strobe stays low past the two-stage synchroniser.
	task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		data <= d;
		wr_n <= 1'b0;
		repeat (5) @(posedge clk);
		wr_n <= 1'b1;
		data <= ~d; // Released bus shows the inverse, not stale data.
		repeat (3) @(posedge clk);
	endtask
	// Read cycle; data is taken at the edge where the drive enable is seen.
	task automatic io_rd(input logic [9:0] a, output logic [7:0] d);
		int n;
		d = 8'hxx;
		@(posedge clk);
		addr <= a;
		rd_n <= 1'b0;
		for (n = 0; n < 12; n++) begin
			@(posedge clk);
			if (data_oe === 1'b1) begin
				d = data_out;
				break;
			end
		end
		rd_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
endmodule

// [testbench/port_nmi_shadow_ram_control_tb.sv]
`timescale 1ns/100ps
`include "pnsr_map.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
// ====================
// Self-checking bench.
module port_nmi_shadow_ram_control_tb import pnsr_pkg::*; ;
	logic clk, rst_b, b20_in, gate, dma_n, slot_in, per_in, chk_n, par_n;
	logic wr_n, rd_n, d_oe, b20, b20_oe, srst, srst_oe, slot_o, slot_oe, per_o, per_oe;
	logic nmi, nmi_oe, spk, spk_oe, m_oe;
	logic map, early_ram_write_n_n, ref_n;
	logic [7:0] blk;
	logic [2:0] cfg;
	logic [9:0] addr;
	logic [7:0] din, dout;
	pnsr_mem_s mem;
	int mismatches, num_checks, cyc;
	pnsr_ctrl u_pnsr_ctrl (.clk(clk), .rst_b(rst_b), .cpu_addr_bit20_in(b20_in),
		.addr20_gate_in(gate), .dma_addr_enable_n(dma_n), .slot_addr_bit0_in(slot_in),
		.peripheral_addr_bit0_in(per_in), .io_write_strobe_n(wr_n), .io_read_strobe_n(rd_n),
		.io_addr(addr), .io_data_in(din), .channel_check_n(chk_n), .parity_error_n(par_n),
		.refresh_n(ref_n), .shadow_map_select(map), .ram_config_select(cfg),
		.early_ram_write_n(early_ram_write_n_n), .mem_block(blk), .gated_addr_bit20(b20),
		.gated_addr_bit20_oe(b20_oe), .soft_reset_out(srst), .soft_reset_oe(srst_oe),
		.slot_addr_bit0_out(slot_o), .slot_addr_bit0_oe(slot_oe), .peripheral_addr_bit0_out(per_o),
		.peripheral_addr_bit0_oe(per_oe), .io_data_out(dout), .io_data_oe(d_oe), .nmi_out(nmi),
		.nmi_oe(nmi_oe), .speaker_out(spk), .speaker_oe(spk_oe), .mem_out(mem), .mem_oe(m_oe));
	pnsr_host_model u_pnsr_host_model (.clk(clk), .data_oe(d_oe), .data_out(dout),
		.wr_n(wr_n), .rd_n(rd_n), .addr(addr), .data(din));
	// Clock at 50 ns period.
	always #25 clk = ~clk;
	// Hang guard, far above the roughly eight hundred cycles the tests take.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Lets n edges pass; callers then see the values settled before the last edge.
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Reads a port and compares it with the expected byte.
	task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] r;
		u_pnsr_host_model.io_rd(a, r);
		`CHK("io read", e, r)
	endtask
	// Writes the shadow port n times with the given byte.
	task automatic shd_wr(input int n, input logic [7:0] d);
		repeat (n) u_pnsr_host_model.io_wr(`PNSR_ADDR_SHADOW, d);
	endtask
	// Shadow register value as read back, unused top bits high.
	function automatic logic [7:0] shd_exp(input logic [7:0] d);
		return {`PNSR_SHD_PAD, d[5:0]};
	endfunction
	// Expected memory decode of one 64K block, from the shadow truth table.
	function automatic pnsr_mem_s mem_exp(input logic m_sel, input logic rd,
		input logic [7:0] bk, input logic [5:0] re_reg, input logic [5:0] wp_reg);
		pnsr_mem_s e;
		logic rom, shd, re, wp;
		logic [2:0] idx;
		e = '0;
		rom = (bk[7:1] == 7'h07) || (bk[7:1] == 7'h7F);
		shd = (bk >= 8'h0A) && (bk <= 8'h0F);
		idx = (rom && !shd) ? 3'h5 : 3'(bk - 8'h0A);
		re = (rom || shd) && re_reg[idx];
		wp = (rom || shd) && wp_reg[idx];
		if (m_sel && (rom || shd)) begin
			e.row = 1'b1;
			e.fast = re;
			e.lmeg = re;
			e.rom = rom && (re || !rd);
			e.col = re ? (rd || !wp) : (!rd && !wp);
		end
		if (rom) begin
			e.fast = 1'b1;
		end
		return e;
	endfunction
	// Main sequence.
	initial begin
		logic [7:0] r, d1, d2, b;
		pnsr_mem_s e;
		int i, k;
		i = $urandom(32'hdd53);
		{clk, rst_b, b20_in, gate, dma_n, slot_in, per_in, chk_n, par_n} = 9'b0_0000_0011;
		cfg = 3'b001;
		{map, early_ram_write_n_n, ref_n} = 3'b111;
		blk = 8'h00;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		wait_n(3);
		rd_chk(`PNSR_ADDR_SHADOW, 8'hC0);
		rd_chk(`PNSR_ADDR_SHADOW, 8'hC0);
		rd_chk(`PNSR_ADDR_SYSCTL, 8'h00);
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			{dma_n, gate, b20_in} <= i[2:0];
			slot_in <= 1'($urandom);
			per_in <= 1'($urandom);
			#1;
			`CHK("gated bit", i[0] & i[1], b20)
			if (i[2]) `CHK("to per", {2'b10, slot_in}, {per_oe, slot_oe, per_o})
			else `CHK("to slot", {2'b10, per_in}, {slot_oe, per_oe, slot_o})
		end
		// Gate input low, so only the control port bit can pass address 20.
		@(posedge clk);
		gate <= 1'b0;
		u_pnsr_host_model.io_wr(`PNSR_ADDR_SYSCTL, 8'hFE);
		rd_chk(`PNSR_ADDR_SYSCTL, 8'h02);
		`CHK("alt gate", 2'b10, {b20, srst})
		u_pnsr_host_model.io_wr(`PNSR_ADDR_SYSCTL, 8'h01);
		rd_chk(`PNSR_ADDR_SYSCTL, 8'h01);
		`CHK("soft reset", 2'b01, {b20, srst})
		d1 = 8'($urandom);
		u_pnsr_host_model.io_wr(`PNSR_ADDR_SPKR, {4'h0, d1[3:2], 2'b11});
		ref_n <= 1'b0;
		u_pnsr_host_model.io_rd(`PNSR_ADDR_SPKR, r);
		ref_n <= 1'b1;
		`CHK("spk port", {3'h0, 1'b1, d1[3:2], 2'b11}, r)
		`CHK("speaker", 1'b1, spk)
		u_pnsr_host_model.io_wr(`PNSR_ADDR_SPKR, 8'h08);
		chk_n <= 1'b0;
		wait_n(4);
		`CHK("nmi masked", 1'b0, nmi)
		u_pnsr_host_model.io_wr(`PNSR_ADDR_NMIMASK, 8'h00);
		wait_n(4);
		`CHK("nmi check", 1'b1, nmi)
		chk_n <= 1'b1;
		par_n <= 1'b0;
		wait_n(4);
		`CHK("nmi par off", 1'b0, nmi)
		u_pnsr_host_model.io_wr(`PNSR_ADDR_SPKR, 8'h04);
		wait_n(4);
		`CHK("nmi parity", 1'b1, nmi)
		rd_chk(`PNSR_ADDR_SPKR, 8'h84);
		u_pnsr_host_model.io_wr(`PNSR_ADDR_NMIMASK, 8'h80);
		wait_n(4);
		`CHK("nmi remask", 1'b0, nmi)
		par_n <= 1'b1;
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		shd_wr(8, 8'($urandom));
		shd_wr(1, d1);
		shd_wr(1, d2);
		rd_chk(`PNSR_ADDR_SHADOW, shd_exp(d1));
		rd_chk(`PNSR_ADDR_SHADOW, shd_exp(d2));
		rd_chk(`PNSR_ADDR_SHADOW, shd_exp(d1));
		u_pnsr_host_model.io_wr(`PNSR_ADDR_SPKR, 8'h00);
		rd_chk(`PNSR_ADDR_SHADOW, shd_exp(d1));
		for (i = 0; i < 2; i++) begin
			shd_wr(5, 8'h15);
			if (i == 0) u_pnsr_host_model.io_wr(`PNSR_ADDR_SPKR, 8'h00);
			else u_pnsr_host_model.io_rd(`PNSR_ADDR_SPKR, r);
			shd_wr(5, 8'h2A);
			rd_chk(`PNSR_ADDR_SHADOW, shd_exp(d1));
		end
		shd_wr(2, 8'h07);
		rd_chk(`PNSR_ADDR_SHADOW, shd_exp(d1));
		// Shadow decode: random registers first, then a hand-picked pair.
		for (k = 0; k < 2; k++) begin
			if (k == 1) begin
				d1 = 8'h33;
				d2 = 8'h30;
				shd_wr(8, 8'h00);
				shd_wr(1, d1);
				shd_wr(1, d2);
			end
			for (i = 0; i < 24; i++) begin
				@(posedge clk);
				b = 8'($urandom_range(7, 18));
				if (b > 8'h0F) begin
					b = b + 8'hEE;
				end
				map <= 1'($urandom);
				early_ram_write_n_n <= 1'($urandom);
				blk <= b;
				wait_n(3);
				e = mem_exp(map, early_ram_write_n_n, blk, d1[5:0], d2[5:0]);
				`CHK("mem decode", e, mem)
			end
		end
		for (i = 0; i < 2; i++) begin
			cfg <= i ? `PNSR_TEST_CFG_B : `PNSR_TEST_CFG_A;
			wait_n(4);
			`CHK("oe all", 8'h00, {b20_oe, srst_oe, slot_oe, per_oe, d_oe, nmi_oe, spk_oe, m_oe})
		end
		tally_and_finish();
	end
endmodule
